// ==== hw/field_ext.sv ====
// Operation
// (R1) Drive 3-bit field onto extended address lines.
// (R2) Fields 0 to 7, 4K each, 32K total.
// (R3) Instruction field extends PC and direct operands.
// (R4) Data field extends indirect operand addresses.
// (R5) Choose field from instruction and major state.
// (R6) Load fields from console or by IO_TRANSFER_INSTRUCTION.
// (R7) Data break peripheral may supply own field.
// (R8) Field state survives interrupts and data breaks.
// (R9) Save field on interrupt, restore on command.
// (R10) Program can read current field values.
// (R11) Flag records user or monitor mode.
// (R12) User-mode privileged instruction traps to monitor mode.
// (R13) Monitor software can enter user mode.
// (R14) Jumper inhibits all time-share functions.
// (R15) Address disable stops driving extended lines.
// (R16) User mode makes processor ignore privileged instructions.
// (R17) Trap flag drives interrupt request and skip.
// (R18) New instruction field waits for jump or call.
// (R19) Reset clears fields and user flag.
//
// The register addresses and the APB slave port are this design's own decisions.
module field_ext
   import field_ext_pkg::*;
(
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Register bus.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   // Processor timing and instruction.
   input wire logic instr_valid,
   input wire logic [WORD_W-1:0] instr_word,
   input wire logic [1:0] major_state,
   input wire logic cycle_end,
   input wire logic io_transfer_instruction,
   input wire logic interrupt_ack,
   input wire logic processor_address_disable,
   // Console and jumper pins.
   input wire logic console_load_field,
   input wire logic [5:0] console_switches,
   input wire logic timeshare_inhibit_jumper,
   // Backplane outputs.
   output logic [FIELD_W-1:0] extended_address_lines,
   output logic extended_address_oe,
   output logic [WORD_W-1:0] bus_data_out,
   output logic bus_data_oe,
   output logic user_mode_flag,
   output logic int_request,
   output logic skip,
   output logic int_inhibit
);

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers.
   logic [7:0] pin_meta_reg;
   logic [7:0] pin_sync_reg;
   logic load_prev_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_meta_reg <= 8'h00;
         pin_sync_reg <= 8'h00;
         load_prev_reg <= 1'b0;
      end else begin
         pin_meta_reg <= {timeshare_inhibit_jumper, console_load_field, console_switches};
         pin_sync_reg <= pin_meta_reg;
         load_prev_reg <= pin_sync_reg[6];
      end
   end
   wire ts_off = pin_sync_reg[7];
   wire console_load = pin_sync_reg[6] && !load_prev_reg;
   wire [2:0] sw_if = pin_sync_reg[5:3];
   wire [2:0] sw_df = pin_sync_reg[2:0];

   ////////////////////////////////////////////////////////////////////////////
   // Instruction decode.
   wire [2:0] op = instr_word[11:9];
   wire our_iot = io_transfer_instruction && op == OP_IOT && instr_word[8:6] == DEV_GROUP;
   wire [2:0] fn = instr_word[2:0];
   wire [2:0] sub = instr_word[5:3];
   wire [2:0] fld = instr_word[5:3];
   wire is_other = our_iot && fn == FN_OTHER;
   wire do_cdf = our_iot && fn != FN_OTHER && fn[0];
   wire do_cif = our_iot && fn != FN_OTHER && fn[1];
   wire do_rdf = is_other && sub == SUB_RDF;
   wire do_rif = is_other && sub == SUB_RIF;
   wire do_rib = is_other && sub == SUB_RIB;
   wire do_rmf = is_other && sub == SUB_RMF;
   wire do_cint = is_other && sub == SUB_CINT;
   wire do_sint = is_other && sub == SUB_SINT;
   wire do_cuf = is_other && sub == SUB_CUF;
   wire do_suf = is_other && sub == SUB_SUF && !ts_off;
   wire indirect = instr_word[8];
   wire group2 = op == OP_OPR && instr_word[8] && !instr_word[0];
   wire privileged = op == OP_IOT || (group2 && (instr_word[1] || instr_word[2]));

   ////////////////////////////////////////////////////////////////////////////
   // Field, buffer and mode state.
   logic [2:0] if_reg, if_next;
   logic [2:0] df_reg, df_next;
   logic [2:0] ib_reg, ib_next;
   logic uf_reg, uf_next;
   logic ub_reg, ub_next;
   logic [6:0] save_reg, save_next;
   logic uint_reg, uint_next;
   logic inh_reg, inh_next;
   logic apb_load;

   wire user_now = uf_reg && !ts_off;
   wire trap = instr_valid && major_state == ST_FETCH && user_now && privileged;
   wire last_pre = (major_state == ST_FETCH && !indirect) || major_state == ST_DEFER;
   wire field_switch = cycle_end && last_pre && (op == OP_JUMP || op == OP_CALL);

   always_comb begin
      if_next = if_reg;
      df_next = df_reg;
      ib_next = ib_reg;
      uf_next = uf_reg;
      ub_next = ub_reg;
      save_next = save_reg;
      uint_next = uint_reg;
      inh_next = inh_reg;
      if (field_switch) begin
         if_next = ib_reg; // R18
         uf_next = ub_reg && !ts_off; // R13 R14
         inh_next = 1'b0;
      end
      if (do_cdf) begin
         df_next = fld; // R6
      end
      if (do_cif) begin
         ib_next = fld; // R6 R18
         inh_next = 1'b1;
      end
      if (apb_load) begin
         df_next = pwdata[2:0];
         ib_next = pwdata[5:3];
         inh_next = 1'b1;
      end
      if (do_rmf) begin
         ib_next = save_reg[5:3]; // R9
         df_next = save_reg[2:0];
         ub_next = save_reg[6] && !ts_off;
         inh_next = 1'b1;
      end
      if (do_suf) begin
         ub_next = 1'b1; // R13
         inh_next = 1'b1;
      end
      if (do_cuf) begin
         ub_next = 1'b0;
      end
      if (do_cint) begin
         uint_next = 1'b0;
      end
      if (console_load) begin
         if_next = sw_if; // R6
         ib_next = sw_if;
         df_next = sw_df;
      end
      if (interrupt_ack) begin
         save_next = {uf_reg, if_reg, df_reg}; // R8 R9
         if_next = 3'h0;
         ib_next = 3'h0;
         df_next = 3'h0;
         uf_next = 1'b0;
         ub_next = 1'b0;
      end
      if (trap) begin
         uint_next = 1'b1; // R12
         uf_next = 1'b0;
         ub_next = 1'b0;
      end
      if (ts_off) begin
         uf_next = 1'b0; // R14
         ub_next = 1'b0;
         uint_next = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         if_reg <= FIELD_RST; // R19
         df_reg <= FIELD_RST;
         ib_reg <= FIELD_RST;
         uf_reg <= 1'b0;
         ub_reg <= 1'b0;
         save_reg <= 7'h00;
         uint_reg <= 1'b0;
         inh_reg <= 1'b0;
      end else begin
         if_reg <= if_next;
         df_reg <= df_next;
         ib_reg <= ib_next;
         uf_reg <= uf_next;
         ub_reg <= ub_next;
         save_reg <= save_next;
         uint_reg <= uint_next;
         inh_reg <= inh_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Extended address output and data bus reads.
   wire use_df = major_state == ST_EXECUTE && indirect && op < OP_CALL; // R4 R5
   wire [2:0] ema_sel = use_df ? df_reg : if_reg; // R2 R3
   wire [11:0] rd_word = do_rdf ? {6'h00, df_reg, 3'h0} :
                         do_rif ? {6'h00, if_reg, 3'h0} :
                         {5'h00, save_reg};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         extended_address_lines <= 3'h0;
         extended_address_oe <= 1'b0;
         bus_data_out <= 12'h000;
         bus_data_oe <= 1'b0;
      end else begin
         extended_address_lines <= processor_address_disable ? 3'h0 : ema_sel; // R1 R15
         extended_address_oe <= !processor_address_disable; // R7 R15
         bus_data_out <= rd_word; // R10
         bus_data_oe <= do_rdf || do_rif || do_rib;
      end
   end

   assign user_mode_flag = user_now; // R11 R16
   assign int_request = uint_reg; // R17
   assign skip = do_sint && uint_reg; // R17
   assign int_inhibit = inh_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Register bus slave and interrupt.
   logic [EV_W-1:0] ev_reg, ev_next;
   logic [EV_W-1:0] mask_reg;
   wire access = psel && penable;
   wire hit_fs = paddr == FIELD_STATUS_OFS;
   wire hit_ev = paddr == EVENT_STATUS_OFS;
   wire hit_mask = paddr == EVENT_MASK_OFS;
   wire hit_load = paddr == FIELD_LOAD_OFS;
   wire mapped = hit_fs || hit_ev || hit_mask || hit_load;
   wire [EV_W-1:0] ev_set = {field_switch, interrupt_ack, trap};
   wire ev_clr = access && pwrite && hit_ev;
   assign apb_load = access && pwrite && hit_load;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign irq = |(ev_reg & mask_reg);

   always_comb begin
      ev_next = ev_reg;
      if (ev_clr) begin
         ev_next = ev_reg & ~pwdata[EV_W-1:0];
      end
      ev_next = ev_next | ev_set;
   end

   wire [31:0] fs_word = {13'h0000, uint_reg, ub_reg, uf_reg, save_reg, ib_reg, if_reg, df_reg};
   wire [31:0] rd_mux = hit_fs ? fs_word :
                        hit_ev ? {29'h0, ev_reg} :
                        hit_mask ? {29'h0, mask_reg} :
                        hit_load ? {26'h0, ib_reg, df_reg} : 32'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ev_reg <= 3'h0;
         mask_reg <= MASK_RST;
         prdata <= 32'h0;
      end else begin
         ev_reg <= ev_next;
         if (access && pwrite && hit_mask) begin
            mask_reg <= pwdata[EV_W-1:0];
         end
         if (psel && !penable && !pwrite) begin
            prdata <= rd_mux;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks.
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_trap;
      trap;
   endsequence
   sequence s_monitor;
      !user_mode_flag && int_request;
   endsequence

   property p_ema_disable;
      processor_address_disable |=> !extended_address_oe && extended_address_lines == 3'h0;
   endproperty
   a_ema_disable: assert property (p_ema_disable) else $error("lines driven during disable"); // R15

   property p_ema_df;
      !processor_address_disable && use_df |=> extended_address_lines == $past(df_reg);
   endproperty
   a_ema_df: assert property (p_ema_df) else $error("indirect operand not on data field"); // R4

   property p_ema_if;
      !processor_address_disable && !use_df |=> extended_address_lines == $past(if_reg);
   endproperty
   a_ema_if: assert property (p_ema_if) else $error("direct access not on instruction field"); // R3

   property p_trap;
      s_trap |=> s_monitor;
   endproperty
   a_trap: assert property (p_trap) else $error("trap did not return to monitor"); // R12

   property p_irq_skip;
      int_request && !do_cint && !ts_off |=> int_request && (skip || !do_sint);
   endproperty
   a_irq_skip: assert property (p_irq_skip) else $error("trap flag not on request"); // R17

   property p_if_hold;
      !field_switch && !console_load && !interrupt_ack |=> $stable(if_reg);
   endproperty
   a_if_hold: assert property (p_if_hold) else $error("field changed early"); // R18

   property p_save;
      interrupt_ack |=> save_reg == $past({uf_reg, if_reg, df_reg}) && if_reg == 3'h0;
   endproperty
   a_save: assert property (p_save) else $error("return field not saved"); // R9

   property p_inhibit;
      ts_off |=> !uf_reg && !ub_reg && !int_request;
   endproperty
   a_inhibit: assert property (p_inhibit) else $error("time-share not inhibited"); // R14

   property p_read;
      do_rif |=> bus_data_oe && bus_data_out[5:3] == $past(if_reg);
   endproperty
   a_read: assert property (p_read) else $error("field read wrong"); // R10

endmodule : field_ext

// ==== hw/field_ext_pkg.sv ====
package field_ext_pkg;
   // Field geometry.
   localparam int FIELD_W = 3;
   localparam int BANK_WORDS = 4096;
   localparam int NUM_FIELDS = 8;
   localparam int TOTAL_WORDS = 32768;
   localparam int WORD_W = 12;
   // Register byte offsets.
   localparam logic [11:0] FIELD_STATUS_OFS = 12'h000;
   localparam logic [11:0] EVENT_STATUS_OFS = 12'h004;
   localparam logic [11:0] EVENT_MASK_OFS = 12'h008;
   localparam logic [11:0] FIELD_LOAD_OFS = 12'h00c;
   // Event bit positions and reset values.
   localparam int EV_TRAP = 0;
   localparam int EV_SAVE = 1;
   localparam int EV_SWITCH = 2;
   localparam int EV_W = 3;
   localparam logic [2:0] FIELD_RST = 3'h0;
   localparam logic [2:0] MASK_RST = 3'h0;
   // Processor major states.
   localparam logic [1:0] ST_FETCH = 2'h0;
   localparam logic [1:0] ST_DEFER = 2'h1;
   localparam logic [1:0] ST_EXECUTE = 2'h2;
   // Opcodes and instruction fields.
   localparam logic [2:0] OP_JUMP = 3'h5;
   localparam logic [2:0] OP_CALL = 3'h4;
   localparam logic [2:0] OP_IOT = 3'h6;
   localparam logic [2:0] OP_OPR = 3'h7;
   localparam logic [2:0] DEV_GROUP = 3'h2;
   localparam logic [2:0] FN_OTHER = 3'h4;
   localparam logic [2:0] SUB_CINT = 3'h0;
   localparam logic [2:0] SUB_RDF = 3'h1;
   localparam logic [2:0] SUB_RIF = 3'h2;
   localparam logic [2:0] SUB_RIB = 3'h3;
   localparam logic [2:0] SUB_RMF = 3'h4;
   localparam logic [2:0] SUB_SINT = 3'h5;
   localparam logic [2:0] SUB_CUF = 3'h6;
   localparam logic [2:0] SUB_SUF = 3'h7;
endpackage : field_ext_pkg

// ==== sim/cpu_model.sv ====
module cpu_model
   import field_ext_pkg::*;
(
   // Clock.
   input wire logic pclk,
   // Processor timing and instruction.
   output logic instr_valid,
   output logic [WORD_W-1:0] instr_word,
   output logic [1:0] major_state,
   output logic cycle_end,
   output logic io_transfer_instruction,
   output logic interrupt_ack,
   output logic processor_address_disable
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      instr_valid = 1'b0;
      instr_word = 12'h000;
      major_state = ST_FETCH;
      cycle_end = 1'b0;
      io_transfer_instruction = 1'b0;
      interrupt_ack = 1'b0;
      processor_address_disable = 1'b0;
   end
   //////////////////////////////////////////////////////////////////////
   // One memory cycle; the word stays on as the processor holds it.
   task automatic step(input logic [1:0] st, input logic [11:0] w, input logic iv,
         input logic io, input logic ce, input logic ack);
      @(posedge pclk);
      major_state <= st;
      instr_word <= w;
      instr_valid <= iv;
      io_transfer_instruction <= io;
      cycle_end <= ce;
      interrupt_ack <= ack;
      @(posedge pclk);
      instr_valid <= 1'b0;
      io_transfer_instruction <= 1'b0;
      cycle_end <= 1'b0;
      interrupt_ack <= 1'b0;
   endtask : step
   // A break device takes the extended lines for its own field.
   task automatic brk(input logic on);
      @(posedge pclk);
      processor_address_disable <= on;
   endtask : brk
endmodule : cpu_model

// ==== sim/memory_field_extension_timeshare_tb_top.sv ====
module memory_field_extension_timeshare_tb_top
   import field_ext_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic er, iv, ce, io, ack, dis, cload, jmp_fit, oe, bdoe, ufl, intr, skp, inh;
   logic [11:0] iw, bdo;
   logic [1:0] ms;
   logic [5:0] sw;
   logic [2:0] ext;
   logic [7:0] seed;
   int failures, n_tests, df, ib, ifv, uf, ub, trap, save;
   logic skp_seen = 1'b0;
   field_ext field_ext_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq(irq), .instr_valid(iv), .instr_word(iw), .major_state(ms),
      .cycle_end(ce), .io_transfer_instruction(io), .interrupt_ack(ack),
      .processor_address_disable(dis), .console_load_field(cload), .console_switches(sw),
      .timeshare_inhibit_jumper(jmp_fit), .extended_address_lines(ext),
      .extended_address_oe(oe), .bus_data_out(bdo), .bus_data_oe(bdoe),
      .user_mode_flag(ufl), .int_request(intr), .skip(skp), .int_inhibit(inh));
   cpu_model cpu_model_i (.pclk(pclk), .instr_valid(iv), .instr_word(iw), .major_state(ms),
      .cycle_end(ce), .io_transfer_instruction(io), .interrupt_ack(ack),
      .processor_address_disable(dis));
   //////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic rd_st();
      apb(1'b0, FIELD_STATUS_OFS, 32'h0);
      chk("status", {13'h0, trap[0], ub[0], uf[0], save[6:0], ib[2:0], ifv[2:0], df[2:0]}, rd);
   endtask : rd_st
   task automatic jump();
      cpu_model_i.step(ST_FETCH, 12'ha00, 1'b1, 1'b0, 1'b1, 1'b0);
      ifv = ib;
      uf = ub;
   endtask : jump
   task automatic settle();
      repeat (2) @(posedge pclk);
      #1;
   endtask : settle
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : conclude
   //////////////////////////////////////////////////////////////////////
   always @(posedge pclk) begin
      if (skp) begin
         skp_seen <= 1'b1;
      end
   end
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   initial begin
      #40000;
      failures++;
      conclude();
   end
   initial begin
      {presetn, psel, penable, pwrite, cload, jmp_fit} = '0;
      paddr = 12'h000;
      pwdata = 32'h0;
      sw = 6'h00;
      seed = 8'h04;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      chk("ext", 32'h0, {29'h0, ext});
      rd_st();
      apb(1'b1, EVENT_MASK_OFS, 32'h7);
      apb(1'b0, EVENT_MASK_OFS, 32'h0);
      chk("mask", 32'h7, rd);
      apb(1'b0, 12'h010, 32'h0);
      chk("slverr", 32'h1, {31'h0, er});
      for (int i = 0; i < 8; i++) begin
         cpu_model_i.step(ST_FETCH, 12'hc81 | 12'(i << 3), 1'b0, 1'b1, 1'b0, 1'b0);
         df = i;
         rd_st();
      end
      cpu_model_i.step(ST_FETCH, 12'hc9a, 1'b0, 1'b1, 1'b0, 1'b0);
      ib = 3;
      rd_st();
      chk("inhibit", 32'h1, {31'h0, inh});
      jump();
      rd_st();
      chk("inhibit_end", 32'h0, {31'h0, inh});
      settle();
      chk("ext_if", ifv, {29'h0, ext});
      cpu_model_i.step(ST_EXECUTE, 12'h100, 1'b0, 1'b0, 1'b0, 1'b0);
      settle();
      chk("ext_df", df, {29'h0, ext});
      cpu_model_i.brk(1'b1);
      settle();
      chk("ext_oe", 32'h0, {31'h0, oe});
      cpu_model_i.brk(1'b0);
      seed = lfsr(seed);
      sw <= seed[5:0];
      cload <= 1'b1;
      repeat (6) @(posedge pclk);
      cload <= 1'b0;
      ifv = seed[5:3];
      ib = ifv;
      df = seed[2:0];
      rd_st();
      cpu_model_i.step(ST_FETCH, 12'hcbc, 1'b0, 1'b1, 1'b0, 1'b0);
      ub = 1;
      jump();
      settle();
      chk("user", 32'h1, {31'h0, ufl});
      cpu_model_i.step(ST_FETCH, 12'h000, 1'b0, 1'b0, 1'b0, 1'b1);
      save = (uf << 6) | (ifv << 3) | df;
      {ifv, ib, df, uf, ub} = '0;
      rd_st();
      cpu_model_i.step(ST_FETCH, 12'hc9c, 1'b0, 1'b1, 1'b0, 1'b0);
      #1;
      chk("rib", save, {20'h0, bdo});
      chk("rib_oe", 32'h1, {31'h0, bdoe});
      cpu_model_i.step(ST_FETCH, 12'hca4, 1'b0, 1'b1, 1'b0, 1'b0);
      df = save & 7;
      ib = (save >> 3) & 7;
      ub = save >> 6;
      jump();
      rd_st();
      cpu_model_i.step(ST_FETCH, 12'hc94, 1'b0, 1'b1, 1'b0, 1'b0);
      #1;
      chk("rif", ifv << 3, {20'h0, bdo});
      apb(1'b1, EVENT_STATUS_OFS, 32'h7);
      apb(1'b1, EVENT_MASK_OFS, 32'h1);
      cpu_model_i.step(ST_FETCH, 12'hc01, 1'b1, 1'b0, 1'b0, 1'b0);
      cpu_model_i.step(ST_FETCH, 12'hcac, 1'b0, 1'b1, 1'b0, 1'b0);
      trap = 1;
      uf = 0;
      ub = 0;
      settle();
      chk("int_request", 32'h1, {31'h0, intr});
      chk("skip", 32'h1, {31'h0, skp_seen});
      chk("irq", 32'h1, {31'h0, irq});
      rd_st();
      apb(1'b1, EVENT_STATUS_OFS, 32'h1);
      chk("irq_clr", 32'h0, {31'h0, irq});
      cpu_model_i.step(ST_FETCH, 12'hc84, 1'b0, 1'b1, 1'b0, 1'b0);
      trap = 0;
      settle();
      chk("int_clear", 32'h0, {31'h0, intr});
      cpu_model_i.step(ST_FETCH, 12'hcbc, 1'b0, 1'b1, 1'b0, 1'b0);
      ub = 1;
      jump();
      jmp_fit <= 1'b1;
      repeat (4) @(posedge pclk);
      uf = 0;
      ub = 0;
      chk("user_off", 32'h0, {31'h0, ufl});
      cpu_model_i.step(ST_FETCH, 12'hcbc, 1'b0, 1'b1, 1'b0, 1'b0);
      jump();
      rd_st();
      conclude();
   end
endmodule : memory_field_extension_timeshare_tb_top
